// ==== src/cfg_receiver.sv ====
// synthesizer end: write-only serial configuration receiver and control
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cfg_receiver (
   input wire logic sys_clk,
   input wire logic sys_rst,
   serial_cfg_if.device link,
   input wire logic [3:0] hw_freq_strap,
   input wire logic synth_clk_phase,
   output logic [3:0] freq_code,
   output logic spread_on,
   output logic [2:0] clk_level,
   output logic [2:0] clk_oe_n
);

   // ***************************************************************
   // link domain: runs on the serial clock line
   // ***************************************************************
   logic link_clk;
   logic link_data;
   logic rise_data_r;
   logic start_seen_r;
   logic [6:0] bit_cnt_r;
   logic [6:0] bit_cnt_nxt;
   logic [7:0] shift_r;
   logic [7:0] byte_val;
   logic [3:0] byte_seq;
   logic in_frame;
   logic byte_done;
   logic addr_ok_r;
   logic rx_en_r;
   logic rx_tog_r;
   logic [7:0] rx_byte_r;
   logic [2:0] rx_idx_r;

   assign link_clk = link.serial_clock_line;
   assign link_data = link.serial_data_line;

   // data is only allowed to move while the clock is low, so a sample
   // taken at the rising edge is the bit itself
   always_ff @(posedge link_clk) begin
      rise_data_r <= link_data;
   end

   // a fall of data during the high phase is a start; seen at the fall
   // of the clock and consumed by the next rising edge
   always_ff @(negedge link_clk) begin
      start_seen_r <= rise_data_r & ~link_data;
   end

   // frame position and incoming byte
   assign in_frame = (bit_cnt_r != 7'h00) && (bit_cnt_r < cfg_pkg::FRAME_BITS);
   assign bit_cnt_nxt = bit_cnt_r + 7'h01;
   assign byte_val = {shift_r[6:0], link_data}; // msb arrives first
   assign byte_seq = bit_cnt_nxt[6:3] - 4'h1;
   assign byte_done = !start_seen_r && in_frame && (bit_cnt_nxt[2:0] == 3'h0);

   // bit counter: restarted by every start, stops after the last bit so
   // that the stop sequence and extra clocks are harmless
   always_ff @(posedge link_clk) begin
      if (start_seen_r) begin
         bit_cnt_r <= 7'h01;
         shift_r <= {7'h00, link_data};
      end else if (in_frame) begin
         bit_cnt_r <= bit_cnt_nxt; // every byte counted, also ignored ones
         shift_r <= byte_val;
      end
   end

   // byte sorting: address check, two ignored bytes, then data bytes.
   // the link side has no reset of its own because its clock may stand
   // still; every start puts it back into a known state instead
   always_ff @(posedge link_clk) begin
      if (start_seen_r) begin
         addr_ok_r <= 1'b0;
         rx_en_r <= 1'b0;
         rx_tog_r <= 1'b0;
      end else if (byte_done) begin
         if (byte_seq == 4'h0) begin
            addr_ok_r <= (byte_val == cfg_pkg::SLAVE_ADDR);
         end else if (byte_seq >= cfg_pkg::FIRST_DATA_SEQ && addr_ok_r) begin
            rx_byte_r <= byte_val; // whole byte only
            rx_idx_r <= 3'(byte_seq - cfg_pkg::FIRST_DATA_SEQ);
            rx_en_r <= 1'b1;
            rx_tog_r <= ~rx_tog_r;
         end
      end
   end

   // ***************************************************************
   // crossing into the system clock domain
   // ***************************************************************
   logic rx_tog_s;
   logic tog_seen_r;
   logic rx_event;
   logic [3:0] strap_s;

   // toggle crossing; byte and index stay still for eight more link
   // clocks, far longer than the synchroniser needs
   cfg_sync2 #(.WIDTH(1)) u_tog_sync (
      .clk(sys_clk),
      .d(rx_tog_r),
      .q(rx_tog_s)
   );

   // strap pins come from outside and are synchronised before use
   cfg_sync2 #(.WIDTH(4)) u_strap_sync (
      .clk(sys_clk),
      .d(hw_freq_strap),
      .q(strap_s)
   );

   // a toggle that flips back at a start carries no payload, so the
   // enable travelling with it keeps the registers untouched
   assign rx_event = (rx_tog_s != tog_seen_r) && rx_en_r;

   // follows the toggle under reset too, so a byte caught before or
   // during reset is not applied once reset lets go
   always_ff @(posedge sys_clk) begin
      tog_seen_r <= rx_tog_s;
   end

   // ***************************************************************
   // configuration registers
   // ***************************************************************
   logic [7:0] freq_mode_r;
   logic [7:0] clk_enable_r;

   // data bytes 2 to 7 are accepted on the link and dropped here: this
   // block owns no outputs for them
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         freq_mode_r <= cfg_pkg::DB0_DEFAULT;
         clk_enable_r <= cfg_pkg::DB1_DEFAULT;
      end else if (rx_event) begin
         if (rx_idx_r == cfg_pkg::DB_FREQ_MODE) begin
            freq_mode_r <= rx_byte_r;
         end
         if (rx_idx_r == cfg_pkg::DB_CLK_ENABLE) begin
            clk_enable_r <= rx_byte_r;
         end
      end
   end

   // ***************************************************************
   // frequency selection and gradual move
   // ***************************************************************
   logic [3:0] sw_select;
   localparam int STEP_W = cfg_pkg::STEP_CNT_W;
   logic [3:0] target_code;
   logic [STEP_W-1:0] step_cnt_r;
   logic step_tick;

   // software select bits in their scattered positions
   assign sw_select = {freq_mode_r[cfg_pkg::SEL3_BIT],
                       freq_mode_r[cfg_pkg::SEL2_BIT],
                       freq_mode_r[cfg_pkg::SEL1_BIT],
                       freq_mode_r[cfg_pkg::SEL0_BIT]};
   assign target_code = freq_mode_r[cfg_pkg::FSRC_BIT] ? sw_select
                                                       : strap_s;
   assign step_tick = (step_cnt_r == STEP_W'(cfg_pkg::FREQ_STEP_CYCLES - 1));

   // step interval counter; free running keeps the move rate fixed
   always_ff @(posedge sys_clk) begin
      if (sys_rst || step_tick) begin
         step_cnt_r <= '0;
      end else begin
         step_cnt_r <= step_cnt_r + STEP_W'(1);
      end
   end

   // one code per interval toward the target, never a jump; the
   // synthesizer loop sees a slow walk it can track
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         freq_code <= 4'h0;
      end else if (step_tick && freq_code < target_code) begin
         freq_code <= freq_code + 4'h1;
      end else if (step_tick && freq_code > target_code) begin
         freq_code <= freq_code - 4'h1;
      end
   end

   // ***************************************************************
   // output mode and clock gating
   // ***************************************************************
   cfg_pkg::out_mode_t mode;
   logic three_state;

   // the reserved mode code behaves as normal operation
   assign mode = cfg_pkg::out_mode_t'(freq_mode_r[cfg_pkg::MODE_LSB +: 2]);
   assign three_state = (mode == cfg_pkg::MODE_TRISTATE);

   // position of each gated clock's enable bit in data byte 1
   function automatic int enable_pos(input int idx);
      int pos;
      pos = cfg_pkg::EN_PROCF_BIT;
      if (idx == 1) begin
         pos = cfg_pkg::EN_PROC2_BIT;
      end else if (idx == 2) begin
         pos = cfg_pkg::EN_MEMFB_BIT;
      end
      return pos;
   endfunction

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         spread_on <= 1'b0;
      end else begin
         spread_on <= (mode == cfg_pkg::MODE_SPREAD);
      end
   end

   // disabled clocks are held low with the driver on; only the
   // three-state mode releases the pins
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         clk_level <= 3'h0;
         clk_oe_n <= 3'h0;
      end else begin
         for (int i = 0; i < cfg_pkg::NUM_GATED_CLKS; i++) begin
            clk_oe_n[i] <= three_state;
            clk_level[i] <= synth_clk_phase & ~three_state &
                            clk_enable_r[enable_pos(i)];
         end
      end
   end

endmodule
`default_nettype wire

// ==== src/cfg_pkg.sv ====
// shared constants for the serial configuration link of the clock synthesizer
package cfg_pkg;

   // ***************************************************************
   // frame layout
   // ***************************************************************
   localparam logic [7:0] SLAVE_ADDR = 8'hd2;
   localparam int BITS_PER_BYTE = 8;
   localparam int FRAME_BYTES = 11;
   localparam logic [6:0] FRAME_BITS = 7'h58;
   localparam logic [3:0] FIRST_DATA_SEQ = 4'h3;
   localparam logic [2:0] DB_FREQ_MODE = 3'h0;
   localparam logic [2:0] DB_CLK_ENABLE = 3'h1;

   // ***************************************************************
   // data byte 0 fields
   // ***************************************************************
   localparam int SEL3_BIT = 2;
   localparam int SEL2_BIT = 6;
   localparam int SEL1_BIT = 5;
   localparam int SEL0_BIT = 4;
   localparam int FSRC_BIT = 3;
   localparam int MODE_LSB = 0;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_RESERVED = 2'h1,
      MODE_SPREAD = 2'h2,
      MODE_TRISTATE = 2'h3
   } out_mode_t;

   // ***************************************************************
   // data byte 1 fields: memory feedback, processor two, free-running
   // ***************************************************************
   localparam int NUM_GATED_CLKS = 3;
   localparam int EN_MEMFB_BIT = 3;
   localparam int EN_PROC2_BIT = 1;
   localparam int EN_PROCF_BIT = 0;

   // ***************************************************************
   // values after reset and write masks for reserved bits
   // ***************************************************************
   localparam logic [7:0] DB0_DEFAULT = 8'h00;
   localparam logic [7:0] DB1_DEFAULT = 8'h0b;
   localparam logic [7:0] DB2_DEFAULT = 8'h5f;
   localparam logic [7:0] DB3_DEFAULT = 8'h37;
   localparam logic [7:0] DB5_DEFAULT = 8'h13;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] DB0_WRITE_MASK = 8'h7f;
   localparam logic [7:0] DB1_WRITE_MASK = 8'h0b;
   localparam logic [7:0] CMD_DEFAULT = 8'h00;
   localparam logic [7:0] COUNT_DEFAULT = 8'h08;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int SYS_CLK_NS = 4;
   localparam int FREQ_STEP_NS = 1000;
   localparam int FREQ_STEP_CYCLES =
      (FREQ_STEP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int STEP_CNT_W = 8;
   localparam int LINK_HALF_CYCLES = 4;
   localparam int LEAD_PULSES = 3;

   // ***************************************************************
   // controller register map (byte offsets on the command port)
   // ***************************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_FRAME_FIRST = 4'h1;
   localparam logic [3:0] REG_FRAME_LAST = 4'hb;
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_BUSY_BIT = 0;

endpackage

// ==== src/serial_cfg_if.sv ====
// two-wire configuration link between controller and synthesizer
`timescale 1ns/1ns
`default_nettype none
interface serial_cfg_if;
   logic serial_clock_line;
   logic serial_data_line;

   // controller makes both wires
   modport host (
      output serial_clock_line,
      output serial_data_line
   );

   // the synthesizer only listens, nothing is ever driven back
   modport device (
      input serial_clock_line,
      input serial_data_line
   );
endinterface
`default_nettype wire

// ==== src/cfg_sync2.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module cfg_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      meta_r <= d;
      q <= meta_r;
   end
endmodule
`default_nettype wire

// ==== src/cfg_sender.sv ====
// controller end: drives eleven-byte configuration frames onto the link
`timescale 1ns/1ns
`default_nettype none
module cfg_sender (
   input wire logic sys_clk,
   input wire logic sys_rst,
   serial_cfg_if.host link,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);

   // ***************************************************************
   // frame buffer: address, command, count, data 0-7
   // ***************************************************************
   typedef enum logic [2:0] {S_IDLE, S_LEAD, S_START, S_BITS, S_STOP} seq_t;
   seq_t state_r;
   logic [7:0] tx_mem [0:cfg_pkg::FRAME_BYTES-1];
   logic [3:0] wr_idx;
   logic busy;
   logic go;

   assign busy = (state_r != S_IDLE);
   assign wr_idx = reg_addr - cfg_pkg::REG_FRAME_FIRST;
   assign go = reg_wr && reg_addr == cfg_pkg::REG_CTRL &&
               reg_wdata[cfg_pkg::CTRL_GO_BIT] && !busy;

   function automatic logic [7:0] frame_default(input int idx);
      logic [7:0] v;
      v = cfg_pkg::ZERO_BYTE;
      case (idx)
         0: v = cfg_pkg::SLAVE_ADDR;
         1: v = cfg_pkg::CMD_DEFAULT;
         2: v = cfg_pkg::COUNT_DEFAULT;
         3: v = cfg_pkg::DB0_DEFAULT;
         4: v = cfg_pkg::DB1_DEFAULT;
         5: v = cfg_pkg::DB2_DEFAULT;
         6: v = cfg_pkg::DB3_DEFAULT;
         8: v = cfg_pkg::DB5_DEFAULT;
         default: v = cfg_pkg::ZERO_BYTE;
      endcase
      return v;
   endfunction

   // writes while a frame is on the wire are dropped so a frame never
   // mixes old and new bytes; reserved bits of bytes 0 and 1 forced low
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < cfg_pkg::FRAME_BYTES; i++) begin
            tx_mem[i] <= frame_default(i);
         end
      end else if (reg_wr && !busy && reg_addr >= cfg_pkg::REG_FRAME_FIRST &&
                   reg_addr <= cfg_pkg::REG_FRAME_LAST) begin
         if (wr_idx == 4'h3) begin
            tx_mem[wr_idx] <= reg_wdata & cfg_pkg::DB0_WRITE_MASK;
         end else if (wr_idx == 4'h4) begin
            tx_mem[wr_idx] <= reg_wdata & cfg_pkg::DB1_WRITE_MASK;
         end else begin
            tx_mem[wr_idx] <= reg_wdata;
         end
      end
   end

   // read data stands in the cycle after the strobe only
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == cfg_pkg::REG_CTRL) begin
         reg_rdata <= {7'h00, busy};
      end else if (reg_addr <= cfg_pkg::REG_FRAME_LAST) begin
         reg_rdata <= tx_mem[wr_idx];
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ***************************************************************
   // link clock divider and frame sequencer
   // ***************************************************************
   logic [2:0] div_r;
   logic tick;
   logic [6:0] bit_idx_r;
   logic [1:0] ph_r;
   logic tx_bit;

   assign tick = (div_r == 3'(cfg_pkg::LINK_HALF_CYCLES - 1));
   assign tx_bit = tx_mem[bit_idx_r[6:3]][~bit_idx_r[2:0]]; // msb first

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !busy || tick) begin
         div_r <= 3'h0;
      end else begin
         div_r <= div_r + 3'h1;
      end
   end

   // lead pulses with data high let the receiver see a start; each bit
   // is fall, set data, rise so data never moves with the clock high
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= S_IDLE;
         link.serial_clock_line <= 1'b1;
         link.serial_data_line <= 1'b1;
         bit_idx_r <= 7'h00;
         ph_r <= 2'h0;
      end else if (go) begin
         state_r <= S_LEAD;
         bit_idx_r <= 7'h00;
         ph_r <= 2'h0;
      end else if (tick) begin
         unique case (state_r)
            S_IDLE: begin
               link.serial_clock_line <= 1'b1;
            end
            S_LEAD: begin
               link.serial_clock_line <= ~link.serial_clock_line;
               bit_idx_r <= bit_idx_r + 7'h01;
               if (bit_idx_r == 7'(2 * cfg_pkg::LEAD_PULSES - 1)) begin
                  state_r <= S_START;
                  bit_idx_r <= 7'h00;
               end
            end
            S_START: begin
               link.serial_data_line <= 1'b0;
               state_r <= S_BITS;
               ph_r <= 2'h0;
            end
            S_BITS: begin
               ph_r <= ph_r + 2'h1;
               if (ph_r == 2'h0) begin
                  link.serial_clock_line <= 1'b0;
               end else if (ph_r == 2'h1) begin
                  link.serial_data_line <= tx_bit;
               end else begin
                  link.serial_clock_line <= 1'b1;
                  ph_r <= 2'h0;
                  bit_idx_r <= bit_idx_r + 7'h01;
                  if (bit_idx_r == cfg_pkg::FRAME_BITS - 7'h01) begin
                     state_r <= S_STOP; // all eleven bytes sent
                  end
               end
            end
            S_STOP: begin
               ph_r <= ph_r + 2'h1;
               if (ph_r == 2'h0) begin
                  link.serial_clock_line <= 1'b0;
               end else if (ph_r == 2'h1) begin
                  link.serial_data_line <= 1'b0;
               end else if (ph_r == 2'h2) begin
                  link.serial_clock_line <= 1'b1;
               end else begin
                  link.serial_data_line <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== tb/cfg_link_chk.sv ====
// assertion checker watching the two-wire configuration link
`timescale 1ns/1ns
`default_nettype none
module cfg_link_chk (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic serial_clock_line,
   input wire logic serial_data_line
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   logic scl_d_r;
   logic sda_d_r;
   logic in_frame_r;
   logic [6:0] rise_cnt_r;
   logic [10:0] frame_cyc_r;
   logic start;
   logic stop;

   // ***************************************************************
   // frame tracking helpers
   // ***************************************************************
   // start and stop are the only data moves while the clock stays high
   assign start = scl_d_r && serial_clock_line && sda_d_r && !serial_data_line;
   assign stop = scl_d_r && serial_clock_line && !sda_d_r && serial_data_line;

   // previous line levels
   always_ff @(posedge sys_clk) begin
      scl_d_r <= serial_clock_line;
      sda_d_r <= serial_data_line;
   end

   // in-frame flag; reset also clears it since the sender idles the lines
   always_ff @(posedge sys_clk) begin
      if (sys_rst || stop) begin
         in_frame_r <= 1'b0;
      end else if (start) begin
         in_frame_r <= 1'b1;
      end
   end

   // rising clock edges since start, stop pulse included
   always_ff @(posedge sys_clk) begin
      if (start) begin
         rise_cnt_r <= 7'h00;
      end else if (in_frame_r && serial_clock_line && !scl_d_r) begin
         rise_cnt_r <= rise_cnt_r + 7'h01;
      end
   end

   // frame length in cycles, saturating so it never wraps to a pass
   always_ff @(posedge sys_clk) begin
      if (!in_frame_r) begin
         frame_cyc_r <= 11'h000;
      end else if (frame_cyc_r != 11'h7ff) begin
         frame_cyc_r <= frame_cyc_r + 11'h001;
      end
   end

   a_reset_idle: assert property (disable iff (1'b0)
      sys_rst |=> serial_clock_line && serial_data_line)
      else $error("link not idle high under reset");
   a_clk_high_min: assert property (
      $rose(serial_clock_line) |-> serial_clock_line [*4])
      else $error("link clock high phase too short");
   a_clk_low_min: assert property (
      $fell(serial_clock_line) |-> !serial_clock_line [*4])
      else $error("link clock low phase too short");
   a_one_line_moves: assert property (
      !($changed(serial_clock_line) && $changed(serial_data_line)))
      else $error("clock and data changed together");
   a_bit_steady: assert property (
      in_frame_r && $rose(serial_clock_line) |->
         $stable(serial_data_line) [*4])
      else $error("data moved while clock high");
   a_start_outside: assert property (
      start |-> !in_frame_r)
      else $error("start inside a frame");
   a_stop_count: assert property (
      stop |-> in_frame_r && (rise_cnt_r == cfg_pkg::FRAME_BITS + 7'h01))
      else $error("frame bit count wrong at stop");
   a_frame_bound: assert property (
      in_frame_r |-> frame_cyc_r < 11'h4b0)
      else $error("frame too long");
   a_stop_idle: assert property (
      stop |-> (serial_clock_line && serial_data_line) [*4])
      else $error("link not idle after stop");

   c_start: cover property (start);
   c_stop: cover property (stop);
   c_mid_reset: cover property (disable iff (1'b0) sys_rst && in_frame_r);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench: controller and synthesizer ends joined by the link
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic sys_clk, sys_rst, reg_wr, reg_rd, synth_clk_phase, spread_on;
   logic [3:0] reg_addr, hw_freq_strap, freq_code;
   logic [7:0] reg_wdata, reg_rdata, rd_val;
   logic [2:0] clk_level, clk_oe_n;
   int mismatches, checks, cyc;

   serial_cfg_if link_if ();
   cfg_sender cfg_sender_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(link_if), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   cfg_receiver cfg_receiver_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(link_if), .hw_freq_strap(hw_freq_strap),
      .synth_clk_phase(synth_clk_phase), .freq_code(freq_code),
      .spread_on(spread_on), .clk_level(clk_level), .clk_oe_n(clk_oe_n));
   cfg_link_chk cfg_link_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .serial_clock_line(link_if.serial_clock_line),
      .serial_data_line(link_if.serial_data_line));

   // ***************************************************************
   // clocks, timeout and shared tasks
   // ***************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // synthesized clock toggles every cycle so gating shows at once
   always @(posedge sys_clk) synth_clk_phase <= ~synth_clk_phase;
   // about 15k cycles expected; the ceiling leaves wide slack
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   // load address and two data bytes, go, poll busy, allow the crossing
   task automatic send_frame(input logic [7:0] a, b0, b1);
      int n;
      wr(4'h1, a);
      wr(4'h4, b0);
      wr(4'h5, b1);
      wr(4'h0, 8'h01);
      repeat (4) @(posedge sys_clk);
      rd_val = 8'h01;
      for (n = 0; n < 2000 && rd_val[0] !== 1'b0; n++) rd(4'h0);
      chk("busy", 8'h00, rd_val);
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // each step of the code may move by one at most
   task automatic wait_code(input logic [3:0] tgt);
      int n, d;
      logic [3:0] prev;
      prev = freq_code;
      for (n = 0; n < 5000 && freq_code !== tgt; n++) begin
         @(negedge sys_clk);
         d = int'(freq_code) - int'(prev);
         if (d > 1 || d < -1)
            chk("freq_step", {4'h0, prev}, {4'h0, freq_code});
         prev = freq_code;
      end
      chk("freq_code", {4'h0, tgt}, {4'h0, freq_code});
   endtask

   task automatic chk_clk(input logic [7:0] b1);
      logic [2:0] en;
      en = {b1[3], b1[1], b1[0]};
      repeat (3) begin
         @(negedge sys_clk);
         chk("clk_level", {5'h0, en & {3{~synth_clk_phase}}},
            {5'h0, clk_level});
         chk("clk_oe_n", 8'h00, {5'h0, clk_oe_n});
      end
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_defaults;
      logic [7:0] exp [12];
      exp = '{8'h00, 8'hd2, 8'h00, 8'h08, 8'h00, 8'h0b, 8'h5f, 8'h37,
         8'h00, 8'h13, 8'h00, 8'h00};
      @(negedge sys_clk);
      chk("freq_code", 8'h00, {4'h0, freq_code});
      chk("spread_on", 8'h00, {7'h0, spread_on});
      chk("clk_oe_n", 8'h00, {5'h0, clk_oe_n});
      for (int i = 0; i < 12; i++) begin
         rd(4'(i));
         chk("reg", exp[i], rd_val);
      end
      wr(4'hc, 8'hff);
      rd(4'hc);
      chk("unmapped", 8'h00, rd_val);
      wr(4'h4, 8'hff);
      rd(4'h4);
      chk("byte0_mask", 8'h7f, rd_val);
      wr(4'h5, 8'hff);
      rd(4'h5);
      chk("byte1_mask", 8'h0b, rd_val);
   endtask

   // command and count hold junk; bit order reversal would clear bit 3
   task automatic t_sw_select;
      wr(4'h2, 8'hff);
      wr(4'h3, 8'h5a);
      send_frame(8'hd2, 8'h2c, 8'h0b);
      wait_code(4'ha);
   endtask

   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         send_frame(8'hd2, 8'h2c | 8'(m), 8'h0b);
         chk("spread_on", {7'h0, m == 2}, {7'h0, spread_on});
         chk("clk_oe_n", (m == 3) ? 8'h07 : 8'h00, {5'h0, clk_oe_n});
      end
   endtask

   task automatic t_enables;
      logic [7:0] v [4];
      v = '{8'h0a, 8'h09, 8'h03, 8'h0b};
      foreach (v[i]) begin
         send_frame(8'hd2, 8'h2c, v[i]);
         chk_clk(v[i]);
      end
   endtask

   task automatic t_bad_addr;
      send_frame(8'hd3, 8'h2e, 8'h00);
      chk("spread_on", 8'h00, {7'h0, spread_on});
      chk_clk(8'h0b);
   endtask

   // reset lands after data byte 0 went in, in the middle of byte 1
   task automatic t_reset_mid;
      wr(4'h4, 8'h2e);
      wr(4'h0, 8'h01);
      repeat (450) @(posedge sys_clk);
      wr(4'h4, 8'h00);
      rd(4'h0);
      chk("busy", 8'h01, rd_val);
      rd(4'h4);
      chk("byte0_busy", 8'h2e, rd_val);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
      chk("freq_code", 8'h00, {4'h0, freq_code});
      chk("spread_on", 8'h00, {7'h0, spread_on});
      rd(4'h4);
      chk("byte0_reset", 8'h00, rd_val);
      // byte 0 sent before reset under the d3 address left by t_bad_addr is never taken, and must not show after it
      chk("spread_on", 8'h00, {7'h0, spread_on});
      send_frame(8'hd2, 8'h2e, 8'h0b);
      chk("spread_on", 8'h01, {7'h0, spread_on});
   endtask

   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      hw_freq_strap = 4'h5;
      synth_clk_phase = 1'b0;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_defaults();
      wait_code(4'h5);
      t_sw_select();
      t_modes();
      t_enables();
      t_bad_addr();
      t_reset_mid();
      report_and_stop();
   end
endmodule
`default_nettype wire
